// [logic/timer_pkg.sv]
// Shared constants and types of the dual timer/counter block.
package timer_pkg;

  // ****************************************
  // Register indices (byte address is four times the index)
  // ****************************************
  localparam logic [7:0] IDX_CONTROL = 8'h88;
  localparam logic [7:0] IDX_MODE = 8'h89;
  localparam logic [7:0] IDX_T0_LOW = 8'h8a;
  localparam logic [7:0] IDX_T1_LOW = 8'h8b;
  localparam logic [7:0] IDX_T0_HIGH = 8'h8c;
  localparam logic [7:0] IDX_T1_HIGH = 8'h8d;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h90;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h91;
  localparam logic [7:0] IDX_UNMAPPED = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTL_TF1 = 7;
  localparam int CTL_TR1 = 6;
  localparam int CTL_TF0 = 5;
  localparam int CTL_TR0 = 4;
  localparam int CTL_EXT_HI = 3;
  localparam int MOD_TIMER1_GATE_ENABLE = 7;
  localparam int MOD_CT1 = 6;
  localparam int MOD_T1_HI = 5;
  localparam int MOD_T1_LO = 4;
  localparam int MOD_TIMER0_GATE_ENABLE = 3;
  localparam int MOD_CT0 = 2;
  localparam int MOD_T0_HI = 1;
  localparam int MOD_T0_LO = 0;
  localparam int IRQ_T0 = 0;
  localparam int IRQ_T1 = 1;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [3:0] EXT_CFG_RESET = 4'h0;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [3:0] PRESCALE_DIV = 4'hc;
  localparam logic [3:0] PRESCALE_LAST = PRESCALE_DIV - 4'h1;
  localparam logic HRESP_OKAY = 1'b0;

  // ****************************************
  // Enumerations
  // ****************************************
  typedef enum logic [1:0] {MODE_13BIT, MODE_16BIT, MODE_RELOAD, MODE_SPLIT} mode_e;
  typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ_LOAD, BUS_READ_DONE} bus_e;

endpackage

// [logic/pin_sync.sv]
// Two-stage pin synchroniser with a falling-edge detector on the samples.
`timescale 1ns/1ns
module pin_sync
(
  // Clock and reset
  input logic mclk,
  input logic rst,
  // Pin and results
  input logic pin,
  output logic level,
  output logic fall
);

  typedef struct packed
  {
    logic meta;
    logic level;
    logic last;
  } pin_s;

  pin_s s_q;
  pin_s s_d;

  // The first stage feeds only the second; the edge uses stages two and three.
  always_comb
  begin
    s_d = s_q;
    s_d.meta = pin;
    s_d.level = s_q.meta;
    s_d.last = s_q.level;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_q <= '{meta: 1'b1, level: 1'b1, last: 1'b1};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign level = s_q.level;
  assign fall = s_q.last & ~s_q.level;

endmodule // pin_sync

// [logic/dual_timer.sv]
// Dual timer/counter with AHB-Lite register access and overflow interrupt.
//
// Notes on behaviour
// [RL1] Timer mode counts once per twelve clocks.
// [RL2] Counter mode counts count-pin falling edges.
// [RL3] Count pins sampled every clock, then edge-checked.
// [RL4] Each timer has separate high/low count bytes.
// [RL5] Interrupt entry clears the overflow flag.
// [RL6] Software write may clear either flag.
// [RL7] Run bit starts counting; clearing holds count.
// [RL8] Gate bit lets gate pin control counting.
// [RL9] Source bit picks count pin or divided clock.
// [RL10] Two mode bits per timer, four modes.
// [RL11] Mode 0: 5-bit prescaler plus high byte.
// [RL12] Mode 1: full 16-bit cascaded count.
// [RL13] Mode 2: low byte reloads from high byte.
// [RL14] Mode 3: timer 0 splits into two bytes.
// [RL15] Split high byte uses timer 1 run/flag.
// [RL16] Mode 3 only timer 0; timer 1 flagless.
// [RL17] Rollover to zero sets the overflow flag.
// [RL18] Gated: run and gate pin high both needed.
`timescale 1ns/1ns
module dual_timer
  import timer_pkg::*;
(
  // Clock and reset
  input logic mclk,
  input logic rst,
  // AHB-Lite slave
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // External pins
  input logic timer0_count_pin,
  input logic timer1_count_pin,
  input logic timer0_gate_pin,
  input logic timer1_gate_pin,
  // Interrupt entry acknowledges from the processor
  input logic timer0_irq_taken,
  input logic timer1_irq_taken,
  // Interrupt
  output logic irq
);

  // ****************************************
  // Types and state
  // ****************************************
  typedef struct packed
  {
    logic ovf;
    logic [7:0] th;
    logic [7:0] tl;
  } step_s;

  typedef struct packed
  {
    bus_e bus;
    logic [7:0] idx;
    logic [31:0] rdata;
    logic tf1;
    logic tr1;
    logic tf0;
    logic tr0;
    logic [3:0] ext_cfg;
    logic [7:0] timer_mode_select;
    logic [7:0] tl0;
    logic [7:0] th0;
    logic [7:0] tl1;
    logic [7:0] th1;
    logic [3:0] presc;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
  } state_s;

  localparam state_s RESET_STATE = '{
    bus: BUS_IDLE,
    idx: IDX_UNMAPPED,
    rdata: 32'h0000_0000,
    tf1: 1'b0,
    tr1: 1'b0,
    tf0: 1'b0,
    tr0: 1'b0,
    ext_cfg: EXT_CFG_RESET,
    timer_mode_select: MODE_RESET,
    tl0: COUNT_RESET,
    th0: COUNT_RESET,
    tl1: COUNT_RESET,
    th1: COUNT_RESET,
    presc: 4'h0,
    irq_stat: IRQ_RESET,
    irq_mask: IRQ_RESET
  };

  state_s s_q;
  state_s s_d;

  logic t0_level;
  logic t0_fall;
  logic t1_level;
  logic t1_fall;
  logic g0_level;
  logic g1_level;
  mode_e mode0;
  mode_e mode1;
  logic split;
  logic tick;
  logic run0;
  logic run1;
  logic inc0;
  logic inc1;
  logic inc0h;
  step_s st0;
  step_s st1;
  step_s sth;
  logic set0;
  logic set1;
  logic accept;
  logic [7:0] accept_idx;
  logic [7:0] wbyte;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Count pins are only trusted after two flops, so a glitch shorter
  // than a clock may be missed; that is the price of a clean edge.
  pin_sync count0_sync ( // RL3
    .mclk(mclk),
    .rst(rst),
    .pin(timer0_count_pin),
    .level(t0_level),
    .fall(t0_fall)
  );

  pin_sync count1_sync ( // RL3
    .mclk(mclk),
    .rst(rst),
    .pin(timer1_count_pin),
    .level(t1_level),
    .fall(t1_fall)
  );

  pin_sync timer0_gate_enable_sync (
    .mclk(mclk),
    .rst(rst),
    .pin(timer0_gate_pin),
    .level(g0_level),
    .fall()
  );

  pin_sync timer1_gate_enable_sync (
    .mclk(mclk),
    .rst(rst),
    .pin(timer1_gate_pin),
    .level(g1_level),
    .fall()
  );

  // ****************************************
  // Count step of one timer
  // ****************************************
  function automatic step_s step(input mode_e mode, input logic [7:0] tl,
    input logic [7:0] th, input logic inc);
    step_s r;
    logic [8:0] lo;
    logic [8:0] hi;
    r.ovf = 1'b0;
    r.th = th;
    r.tl = tl;
    lo = {1'b0, tl} + 9'h001;
    hi = {1'b0, th} + 9'h001;
    if (inc)
    begin
      case (mode)
        MODE_13BIT:
        begin
          r.tl = {tl[7:5], lo[4:0]}; // RL11
          if (tl[4:0] == 5'h1f)
          begin
            r.th = hi[7:0];
            r.ovf = hi[8]; // RL17
          end
        end
        MODE_16BIT:
        begin
          r.tl = lo[7:0]; // RL12
          if (lo[8])
          begin
            r.th = hi[7:0];
            r.ovf = hi[8]; // RL17
          end
        end
        MODE_RELOAD:
        begin
          r.tl = lo[8] ? th : lo[7:0]; // RL13
          r.ovf = lo[8];
        end
        MODE_SPLIT:
        begin
          r.tl = lo[7:0]; // RL14
          r.ovf = lo[8];
        end
        default:
        begin
          r.tl = tl;
        end
      endcase
    end
    return r;
  endfunction

  // ****************************************
  // Read multiplexer
  // ****************************************
  function automatic logic [7:0] read_byte(input state_s s);
    logic [7:0] v;
    v = 8'h00;
    case (s.idx)
      IDX_CONTROL:
      begin
        v = {s.tf1, s.tr1, s.tf0, s.tr0, s.ext_cfg};
      end
      IDX_MODE:
      begin
        v = s.timer_mode_select;
      end
      IDX_T0_LOW:
      begin
        v = s.tl0;
      end
      IDX_T1_LOW:
      begin
        v = s.tl1;
      end
      IDX_T0_HIGH:
      begin
        v = s.th0;
      end
      IDX_T1_HIGH:
      begin
        v = s.th1;
      end
      IDX_IRQ_STATUS:
      begin
        v = {6'h00, s.irq_stat};
      end
      IDX_IRQ_MASK:
      begin
        v = {6'h00, s.irq_mask};
      end
      default:
      begin
        v = 8'h00;
      end
    endcase
    return v;
  endfunction

  // ****************************************
  // Count enables
  // ****************************************
  assign mode0 = mode_e'(s_q.timer_mode_select[MOD_T0_HI:MOD_T0_LO]); // RL10
  assign mode1 = mode_e'(s_q.timer_mode_select[MOD_T1_HI:MOD_T1_LO]); // RL10
  assign split = (mode0 == MODE_SPLIT);
  assign tick = (s_q.presc == PRESCALE_LAST); // RL1
  assign run0 = s_q.tr0 & (~s_q.timer_mode_select[MOD_TIMER0_GATE_ENABLE] | g0_level); // RL7 RL8 RL18
  // While timer 0 is split, timer 1 loses its run bit and keeps only its gate.
  assign run1 = (split | s_q.tr1) & (~s_q.timer_mode_select[MOD_TIMER1_GATE_ENABLE] | g1_level); // RL8 RL18
  assign inc0 = run0 & (s_q.timer_mode_select[MOD_CT0] ? t0_fall : tick); // RL2 RL9
  // Timer 1 set to the split mode simply holds its count.
  assign inc1 = run1 & (mode1 != MODE_SPLIT) & (s_q.timer_mode_select[MOD_CT1] ? t1_fall : tick); // RL16
  assign inc0h = split & s_q.tr1 & tick; // RL15
  assign st0 = step(mode0, s_q.tl0, s_q.th0, inc0);
  assign st1 = step(mode1, s_q.tl1, s_q.th1, inc1);
  assign sth = step(MODE_SPLIT, s_q.th0, COUNT_RESET, inc0h);
  assign set0 = st0.ovf;
  assign set1 = split ? sth.ovf : st1.ovf; // RL15 RL16

  // ****************************************
  // Bus decode
  // ****************************************
  assign accept = hsel & htrans[1] & hready;
  assign accept_idx = (haddr[31:10] == 22'h000000) ? haddr[9:2] : IDX_UNMAPPED;
  assign wbyte = hwdata[7:0];

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    s_d = s_q;
    s_d.presc = tick ? 4'h0 : s_q.presc + 4'h1; // RL1
    s_d.tl0 = st0.tl;
    s_d.th0 = split ? sth.tl : st0.th;
    s_d.tl1 = st1.tl;
    s_d.th1 = st1.th;
    s_d.tf0 = s_q.tf0 & ~timer0_irq_taken; // RL5
    s_d.tf1 = s_q.tf1 & ~timer1_irq_taken; // RL5
    case (s_q.bus)
      BUS_WRITE:
      begin
        case (s_q.idx)
          IDX_CONTROL:
          begin
            s_d.tf1 = wbyte[CTL_TF1]; // RL6
            s_d.tr1 = wbyte[CTL_TR1]; // RL7
            s_d.tf0 = wbyte[CTL_TF0]; // RL6
            s_d.tr0 = wbyte[CTL_TR0]; // RL7
            s_d.ext_cfg = wbyte[CTL_EXT_HI:0];
          end
          IDX_MODE:
          begin
            s_d.timer_mode_select = wbyte; // RL10
          end
          IDX_T0_LOW:
          begin
            s_d.tl0 = wbyte; // RL4
          end
          IDX_T1_LOW:
          begin
            s_d.tl1 = wbyte; // RL4
          end
          IDX_T0_HIGH:
          begin
            s_d.th0 = wbyte; // RL4
          end
          IDX_T1_HIGH:
          begin
            s_d.th1 = wbyte; // RL4
          end
          IDX_IRQ_MASK:
          begin
            s_d.irq_mask = wbyte[1:0];
          end
          default:
          begin
            s_d.idx = s_q.idx;
          end
        endcase
      end
      BUS_READ_LOAD:
      begin
        s_d.rdata = {24'h000000, read_byte(s_q)};
        if (s_q.idx == IDX_IRQ_STATUS)
        begin
          s_d.irq_stat = IRQ_RESET;
        end
      end
      default:
      begin
        s_d.rdata = s_q.rdata;
      end
    endcase
    // A hardware event in the same cycle as any clear still lands.
    s_d.tf0 = s_d.tf0 | set0; // RL17
    s_d.tf1 = s_d.tf1 | set1; // RL17
    s_d.irq_stat[IRQ_T0] = s_d.irq_stat[IRQ_T0] | set0;
    s_d.irq_stat[IRQ_T1] = s_d.irq_stat[IRQ_T1] | set1;
    // Reads take one wait state so they see any write just before them.
    if (s_q.bus == BUS_READ_LOAD)
    begin
      s_d.bus = BUS_READ_DONE;
    end
    else if (accept)
    begin
      s_d.idx = accept_idx;
      s_d.bus = hwrite ? BUS_WRITE : BUS_READ_LOAD;
    end
    else
    begin
      s_d.bus = BUS_IDLE;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_q <= RESET_STATE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign hreadyout = (s_q.bus != BUS_READ_LOAD);
  assign hrdata = s_q.rdata;
  assign hresp = HRESP_OKAY;
  assign irq = |(s_q.irq_stat & s_q.irq_mask);

endmodule // dual_timer

// [sim/dual_timer_sva.sv]
// Port-level assertions for the dual timer block.
`timescale 1ns/1ns
module dual_timer_chk
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  // Interrupt
  input wire logic irq
);
  default clocking cb @(posedge mclk); endclocking
  wire take = hsel && htrans[1] && hready;
  logic rd_q;

  always_ff @(posedge mclk)
  begin
    rd_q <= !rst && take && !hwrite;
  end

  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_upper;
    disable iff (rst) hrdata[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_hold;
    disable iff (rst) !$stable(hrdata) |-> $past(hreadyout) == 1'b0;
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_rd_wait;
    disable iff (rst) take && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_wr_fast;
    disable iff (rst) take && hwrite |=> hreadyout;
  endproperty
  a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
  property p_wait_one;
    disable iff (rst) !hreadyout |=> hreadyout;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("long wait");
  property p_wait_cause;
    disable iff (rst) !hreadyout |-> rd_q;
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("stray wait");
  property p_rst_bus;
    rst |=> hreadyout && hrdata == 32'h0 && !irq;
  endproperty
  a_rst_bus: assert property (p_rst_bus) else $error("reset state wrong");

  c_read: cover property (take && !hwrite);
  c_write: cover property (take && hwrite);
  c_irq: cover property ($rose(irq));
endmodule // dual_timer_chk

bind dual_timer dual_timer_chk u_chk (.mclk(mclk), .rst(rst), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .hresp(hresp), .irq(irq));

// [sim/count_pin_model.sv]
// Model of the external count and gate pins.
`timescale 1ns/1ns
module count_pin_model
(
  // Clock
  input wire logic mclk,
  // Bench requests
  input wire logic [1:0] fall_req,
  input wire logic [1:0] gate_lvl,
  // Pins
  output logic [1:0] count_pin,
  output logic [1:0] gate_pin
);
  logic [2:0] cnt_q [2] = '{3'h0, 3'h0};

  // Low for three periods, then high: each level outlasts the sampler's two stages.
  always @(posedge mclk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (fall_req[i])
        cnt_q[i] <= 3'h6;
      else if (cnt_q[i] != 3'h0)
        cnt_q[i] <= cnt_q[i] - 3'h1;
    end
  end

  assign count_pin[0] = cnt_q[0] < 3'h4;
  assign count_pin[1] = cnt_q[1] < 3'h4;
  assign gate_pin = gate_lvl;
endmodule // count_pin_model

// [sim/tb_dual_timer.sv]
// Self-checking bench for the dual timer block.
`timescale 1ns/1ns
module tb_dual_timer
  import timer_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] taken = 2'h0;
  logic [1:0] fall_req = 2'h0;
  logic [1:0] gate_lvl = 2'h3;
  logic [1:0] cpin;
  logic [1:0] gpin;
  logic hrdy;
  logic hresp;
  logic irq;
  logic [31:0] hrdata;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  int n;

  dual_timer u_dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
    .hrdata(hrdata), .hresp(hresp), .timer0_count_pin(cpin[0]),
    .timer1_count_pin(cpin[1]), .timer0_gate_pin(gpin[0]), .timer1_gate_pin(gpin[1]),
    .timer0_irq_taken(taken[0]), .timer1_irq_taken(taken[1]), .irq(irq));
  count_pin_model u_pins (.mclk(mclk), .fall_req(fall_req), .gate_lvl(gate_lvl),
    .count_pin(cpin), .gate_pin(gpin));

  initial
  begin
    forever #25 mclk = ~mclk;
  end

  // ****
  // Tasks
  // ****
  task final_report;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic wr, input logic [7:0] i, input logic [7:0] d,
    output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, i, 2'h0};
    do @(posedge mclk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge mclk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask

  task automatic w(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, i, d, q);
  endtask

  task automatic r(input logic [7:0] i, input logic [7:0] e);
    logic [31:0] q;
    xfer(1'b0, i, 8'h00, q);
    chk(q, {24'h0, e});
  endtask

  task automatic pulse();
    fall_req[0] <= 1'b1;
    @(posedge mclk);
    fall_req[0] <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask

  // Bounded so that a silent timer counts as a mismatch, not a hang.
  task automatic wait_irq(output int k);
    k = 0;
    while (irq !== 1'b1 && k < 60)
    begin
      @(posedge mclk);
      k++;
    end
    chk(irq, 1'b1);
  endtask

  task automatic run0(input logic [7:0] m, input logic [7:0] lo, input logic [7:0] hi);
    w(IDX_MODE, m);
    w(IDX_T0_LOW, lo);
    w(IDX_T0_HIGH, hi);
    w(IDX_CONTROL, 8'h10);
  endtask

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      fails++;
      final_report();
    end
  end

  // ****
  // Sequence
  // ****
  initial
  begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    r(IDX_MODE, 8'h00);
    r(IDX_CONTROL, 8'h00);
    w(IDX_T0_LOW, 8'h11);
    w(IDX_T1_LOW, 8'h22);
    w(IDX_T0_HIGH, 8'h33);
    w(IDX_T1_HIGH, 8'h44);
    r(IDX_T0_LOW, 8'h11);
    r(IDX_T1_LOW, 8'h22);
    r(IDX_T0_HIGH, 8'h33);
    r(IDX_T1_HIGH, 8'h44);
    w(IDX_IRQ_STATUS, 8'h03);
    r(IDX_IRQ_STATUS, 8'h00);
    w(IDX_UNMAPPED, 8'hff);
    r(IDX_UNMAPPED, 8'h00);
    w(IDX_IRQ_MASK, 8'h01);
    run0(8'h00, 8'hff, 8'hff);
    wait_irq(n);
    r(IDX_CONTROL, 8'h30);
    taken[0] <= 1'b1;
    @(posedge mclk);
    taken[0] <= 1'b0;
    r(IDX_CONTROL, 8'h10);
    w(IDX_CONTROL, 8'h00);
    r(IDX_T0_LOW, 8'he0);
    r(IDX_T0_HIGH, 8'h00);
    r(IDX_CONTROL, 8'h00);
    r(IDX_IRQ_STATUS, 8'h01);
    r(IDX_IRQ_STATUS, 8'h00);
    chk(irq, 1'b0);
    run0(8'h01, 8'hfe, 8'hff);
    wait_irq(n);
    w(IDX_CONTROL, 8'h00);
    r(IDX_T0_LOW, 8'h00);
    r(IDX_T0_HIGH, 8'h00);
    repeat (30) @(posedge mclk);
    r(IDX_T0_LOW, 8'h00);
    r(IDX_IRQ_STATUS, 8'h01);
    run0(8'h02, 8'hff, 8'hff);
    wait_irq(n);
    r(IDX_IRQ_STATUS, 8'h01);
    wait_irq(n);
    chk(n + 3, 12);
    w(IDX_CONTROL, 8'h00);
    r(IDX_T0_LOW, 8'hff);
    r(IDX_IRQ_STATUS, 8'h01);
    gate_lvl[0] <= 1'b0;
    run0(8'h0d, 8'hfe, 8'hff);
    pulse();
    repeat (24) @(posedge mclk);
    r(IDX_T0_LOW, 8'hfe);
    gate_lvl[0] <= 1'b1;
    pulse();
    r(IDX_T0_LOW, 8'hff);
    pulse();
    wait_irq(n);
    r(IDX_T0_HIGH, 8'h00);
    w(IDX_CONTROL, 8'h00);
    r(IDX_IRQ_STATUS, 8'h01);
    w(IDX_MODE, 8'h03);
    w(IDX_T0_LOW, 8'h00);
    w(IDX_T0_HIGH, 8'hff);
    w(IDX_CONTROL, 8'h40);
    repeat (20) @(posedge mclk);
    r(IDX_CONTROL, 8'hc0);
    r(IDX_T0_LOW, 8'h00);
    w(IDX_T0_LOW, 8'hff);
    w(IDX_CONTROL, 8'h10);
    repeat (20) @(posedge mclk);
    r(IDX_CONTROL, 8'h30);
    r(IDX_IRQ_STATUS, 8'h03);
    w(IDX_MODE, 8'h30);
    w(IDX_T1_LOW, 8'h55);
    w(IDX_CONTROL, 8'h40);
    repeat (30) @(posedge mclk);
    r(IDX_T1_LOW, 8'h55);
    r(IDX_CONTROL, 8'h40);
    w(IDX_CONTROL, 8'h00);
    w(IDX_MODE, 8'h10);
    w(IDX_IRQ_MASK, 8'h00);
    w(IDX_T1_LOW, 8'hff);
    w(IDX_T1_HIGH, 8'hff);
    w(IDX_CONTROL, 8'h40);
    repeat (30) @(posedge mclk);
    chk(irq, 1'b0);
    r(IDX_CONTROL, 8'hc0);
    taken[1] <= 1'b1;
    @(posedge mclk);
    taken[1] <= 1'b0;
    r(IDX_CONTROL, 8'h40);
    w(IDX_CONTROL, 8'h00);
    r(IDX_IRQ_STATUS, 8'h02);
    final_report();
  end
endmodule // tb_dual_timer
